// *** rtl/t1_line_params.svh ***
// Purpose: named constants of the T1 line interface control block
// Assumes: byte addresses on a 32-bit APB
// Notes: definitions only
`ifndef T1_LINE_PARAMS_SVH
`define T1_LINE_PARAMS_SVH
// register byte addresses and the line_iface_ctrl reset value
`define LIC_ADDR 8'h7C
`define IRQ_STATUS_ADDR 8'h80
`define IRQ_MASK_ADDR 8'h84
`define LINE_STATUS_ADDR 8'h88
`define LIC_RESET 8'h00
// line_iface_ctrl field positions
`define BUILD_OUT_SEL_HI 7
`define BUILD_OUT_SEL_LO 5
`define EQ_GAIN_LIMIT 4
`define JITTER_ATTEN_SIDE 3
`define JITTER_BUF_DEPTH_SEL 2
`define JITTER_ATTEN_OFF 1
`define TX_POWER_DOWN 0
// decoded values
`define EQ_LIMIT_NARROW_DB 6'h24
`define EQ_LIMIT_WIDE_DB 6'h1E
`define JA_DEPTH_DEEP 8'h80
`define JA_DEPTH_SHALLOW 8'h20
`define CSU_FIRST_CODE 3'h5
// interrupt bits
`define IRQ_W 2
`define IRQ_LOSS 0
`define IRQ_RESTORE 1
// line status bits
`define STAT_CARRIER_LOSS 0
`define STAT_PLL_LOCKED 1
// clocks and timing
`define PCLK_KHZ 50000
`define PCLK_NS 20
`define MCLK_KHZ 1544
`define OS_FACTOR 16
`define NCO_W 16
`define OS_MID 4'h8
// data decision inside the half-width return-to-zero pulse, not at its trailing edge
`define OS_DATA 4'h4
`define OS_LAST 4'hF
`define OS_SHORT_HIGH_END 4'h7
`define PULSE_NS 324
`define LOCK_MIN 5'h0F
`define LOCK_MAX 5'h11
`define SYNC_STAGES 3
`endif

// *** rtl/t1_line_pkg.sv ***
// Purpose: types shared by the T1 line interface control block
// Assumes: nothing beyond the params header
// Notes: build-out waveforms listed in code order
package t1_line_pkg;
   typedef enum logic [2:0] {
      lbo_dsx_0_133 = 3'h0,
      lbo_dsx_133_266 = 3'h1,
      lbo_dsx_266_399 = 3'h2,
      lbo_dsx_399_533 = 3'h3,
      lbo_dsx_533_655 = 3'h4,
      lbo_csu_7p5db = 3'h5,
      lbo_csu_15db = 3'h6,
      lbo_csu_22p5db = 3'h7
   } lbo_t;

   typedef struct packed {
      lbo_t waveform;
      logic csu_mode;
      logic [5:0] eq_limit_db;
      logic ja_tx_side;
      logic [7:0] ja_depth_bits;
      logic ja_bypass;
      logic tx_power_down;
   } line_cfg_t;
endpackage

// *** rtl/t1_line_interface_control.sv ***
// Purpose: line interface control register, receive clock recovery and transmit pulse timing
// Assumes: APB slave on pclk; mclk, tx clock and receive line arrive asynchronously
// Notes: the x16 clock is a numerically controlled tick, not an analog loop
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "t1_line_params.svh"

// Operation
// [R1] bits 7..5 of line_iface_ctrl select the transmit build-out waveform
// [R2] codes 0..4 are DSX-1 length ranges, codes 5..7 are CSU attenuations
// [R3] bit 4 sets equalizer gain limit: 0 gives -36 dB, 1 gives -30 dB
// [R4] bit 3 places jitter attenuator: 0 receive path, 1 transmit path
// [R5] bit 2 sizes attenuator buffer: 0 gives 128 bits, 1 gives 32 bits
// [R6] bit 1 set bypasses the jitter attenuator entirely
// [R7] bit 0 set powers transmitter down and floats both line outputs
// [R8] master clock at T1 rate is multiplied by sixteen for clock recovery
// [R9] receive line sampled at sixteen times bit rate to recover clock and data
// [R10] recovered clock output falls back to master clock on carrier loss
// [R11] half duty recovered clock with receive attenuator, else shortened high phase
// [R12] transmit pulse shape independent of transmit clock duty cycle
// [R13] line_iface_ctrl reads back the last written value, all eight bits
module t1_line_interface_control
   import t1_line_pkg::*;
#(
   parameter int LOS_BITS = 192
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic mclk,
   input wire logic tx_clock_in,
   input wire logic rx_line_pos,
   input wire logic rx_line_neg,
   input wire logic tx_mark_pos,
   input wire logic tx_mark_neg,
   output logic tx_line_pos,
   output logic tx_line_neg,
   output logic tx_line_oe,
   output logic recovered_clock_out,
   output logic rx_data,
   output logic rx_data_valid,
   output logic carrier_loss,
   output line_cfg_t line_cfg
);

   localparam int NCO_INC = (`OS_FACTOR * `MCLK_KHZ * (1 << `NCO_W)) / `PCLK_KHZ;
   localparam int PULSE_CYC = (`PULSE_NS / `PCLK_NS) < 1 ? 1 : (`PULSE_NS / `PCLK_NS);
   localparam int PULSE_W = $clog2(PULSE_CYC + 1);
   localparam int LOS_W = $clog2(LOS_BITS + 1);

   if (LOS_BITS < 2 || NCO_INC >= (1 << `NCO_W)) begin : g_bad_param
      $error("t1_line_interface_control: unsupported parameter value");
   end

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic line_cfg_t decode_cfg(input logic [7:0] r);
      line_cfg_t c;
      c.waveform = lbo_t'(r[`BUILD_OUT_SEL_HI:`BUILD_OUT_SEL_LO]); // [R1]
      c.csu_mode = (r[`BUILD_OUT_SEL_HI:`BUILD_OUT_SEL_LO] >= `CSU_FIRST_CODE); // [R2]
      c.eq_limit_db = r[`EQ_GAIN_LIMIT] ? `EQ_LIMIT_WIDE_DB : `EQ_LIMIT_NARROW_DB; // [R3]
      c.ja_tx_side = r[`JITTER_ATTEN_SIDE]; // [R4]
      c.ja_depth_bits = r[`JITTER_BUF_DEPTH_SEL] ? `JA_DEPTH_SHALLOW : `JA_DEPTH_DEEP; // [R5]
      c.ja_bypass = r[`JITTER_ATTEN_OFF]; // [R6]
      c.tx_power_down = r[`TX_POWER_DOWN]; // [R7]
      return c;
   endfunction

   function automatic logic addr_is(input logic [31:0] a, input logic [7:0] off);
      return (a[31:8] == 24'h000000) && (a[7:0] == off);
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // 0 mclk, 1 tx clock, 2 rx pos, 3 rx neg
   logic [`SYNC_STAGES-1:0] pin_sync [4];
   logic [3:0] pin_val;
   logic [3:0] pin_raw;

   assign pin_raw = {rx_line_neg, rx_line_pos, tx_clock_in, mclk};

   for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pin_sync[i] <= '0;
            pin_val[i] <= 1'b0;
         end else if (ce) begin
            pin_sync[i] <= {pin_sync[i][`SYNC_STAGES-2:0], pin_raw[i]};
            // accept a change only once the later two stages agree
            if (pin_sync[i][1] == pin_sync[i][2]) begin
               pin_val[i] <= pin_sync[i][2];
            end
         end
      end
   end

   logic mclk_v;
   logic txclk_v;
   logic mark_now;
   assign mclk_v = pin_val[0];
   assign txclk_v = pin_val[1];
   assign mark_now = pin_val[2] | pin_val[3];

   // ---------------------------------------------------------------
   // apb register file
   // ---------------------------------------------------------------
   logic [7:0] line_iface_ctrl;
   logic [`IRQ_W-1:0] irq_status;
   logic [`IRQ_W-1:0] irq_mask;
   logic [`IRQ_W-1:0] irq_event;
   logic pll_locked;
   logic access;
   logic wr_en;
   logic mapped;

   assign access = psel & penable & ~pready;
   assign wr_en = access & pwrite;
   assign mapped = addr_is(paddr, `LIC_ADDR) | addr_is(paddr, `IRQ_STATUS_ADDR) |
                   addr_is(paddr, `IRQ_MASK_ADDR) | addr_is(paddr, `LINE_STATUS_ADDR);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_iface_ctrl <= `LIC_RESET;
      end else if (ce && wr_en && addr_is(paddr, `LIC_ADDR) && pstrb[0]) begin
         line_iface_ctrl <= pwdata[7:0]; // [R13]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= '0;
      end else if (ce && wr_en && addr_is(paddr, `IRQ_MASK_ADDR) && pstrb[0]) begin
         irq_mask <= pwdata[`IRQ_W-1:0];
      end
   end

   // a new event outranks a write-one-to-clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
      end else if (ce) begin
         if (wr_en && addr_is(paddr, `IRQ_STATUS_ADDR) && pstrb[0]) begin
            irq_status <= (irq_status & ~pwdata[`IRQ_W-1:0]) | irq_event;
         end else begin
            irq_status <= irq_status | irq_event;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // one wait state: pready rises on the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else if (ce) begin
         pready <= access;
         pslverr <= access & ~mapped;
         prdata <= '0;
         if (access && !pwrite) begin
            if (addr_is(paddr, `LIC_ADDR)) begin
               prdata <= {24'h000000, line_iface_ctrl}; // [R13]
            end else if (addr_is(paddr, `IRQ_STATUS_ADDR)) begin
               prdata <= {{(32-`IRQ_W){1'b0}}, irq_status};
            end else if (addr_is(paddr, `IRQ_MASK_ADDR)) begin
               prdata <= {{(32-`IRQ_W){1'b0}}, irq_mask};
            end else if (addr_is(paddr, `LINE_STATUS_ADDR)) begin
               prdata <= {30'h00000000, pll_locked, carrier_loss};
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_cfg <= decode_cfg(`LIC_RESET);
      end else if (ce) begin
         line_cfg <= decode_cfg(line_iface_ctrl); // [R1] [R2] [R3] [R4] [R5] [R6]
      end
   end

   // ---------------------------------------------------------------
   // x16 oversampling tick from pclk, and master clock lock check
   // ---------------------------------------------------------------
   // nco runs at sixteen times the master clock; lock watches ticks per period
   logic [`NCO_W:0] nco_acc;
   logic os_tick;
   logic mclk_d;
   logic [4:0] ticks_in_period;

   assign os_tick = nco_acc[`NCO_W];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nco_acc <= '0;
      end else if (ce) begin
         nco_acc <= {1'b0, nco_acc[`NCO_W-1:0]} + (`NCO_W+1)'(NCO_INC); // [R8]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mclk_d <= 1'b0;
         ticks_in_period <= '0;
         pll_locked <= 1'b0;
      end else if (ce) begin
         mclk_d <= mclk_v;
         if (mclk_v && !mclk_d) begin
            pll_locked <= (ticks_in_period >= `LOCK_MIN) && (ticks_in_period <= `LOCK_MAX); // [R8]
            ticks_in_period <= 5'(os_tick);
         end else if (os_tick && ticks_in_period != 5'h1F) begin
            ticks_in_period <= ticks_in_period + 5'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // receive clock and data recovery
   // ---------------------------------------------------------------
   logic [3:0] os_phase;
   logic mark_d;
   logic bit_had_mark;
   logic [LOS_W-1:0] quiet_bits;
   logic rec_clk;
   logic ja_rx_active;

   assign ja_rx_active = ~line_cfg.ja_tx_side & ~line_cfg.ja_bypass;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         os_phase <= '0;
         mark_d <= 1'b0;
         bit_had_mark <= 1'b0;
         rx_data <= 1'b0;
         rx_data_valid <= 1'b0;
      end else if (ce) begin
         rx_data_valid <= 1'b0;
         if (os_tick) begin
            mark_d <= mark_now;
            // realign the bit phase on each pulse's leading edge
            if (mark_now && !mark_d) begin
               os_phase <= 4'h1; // [R9]
            end else begin
               os_phase <= os_phase + 4'h1;
            end
            if (os_phase == `OS_DATA) begin
               rx_data <= mark_now; // [R9]
               rx_data_valid <= 1'b1;
            end
            if (os_phase == `OS_LAST) begin
               bit_had_mark <= mark_now;
            end else if (mark_now) begin
               bit_had_mark <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_bits <= '0;
         carrier_loss <= 1'b0;
      end else if (ce && os_tick) begin
         if (mark_now) begin
            quiet_bits <= '0;
            carrier_loss <= 1'b0; // [R10]
         end else if (os_phase == `OS_LAST && !bit_had_mark) begin
            if (quiet_bits == LOS_W'(LOS_BITS - 1)) begin
               carrier_loss <= 1'b1; // [R10]
            end else begin
               quiet_bits <= quiet_bits + LOS_W'(1);
            end
         end
      end
   end

   assign irq_event[`IRQ_LOSS] = 1'b0 | (ce & os_tick & ~carrier_loss & ~mark_now &
                                 (os_phase == `OS_LAST) & ~bit_had_mark &
                                 (quiet_bits == LOS_W'(LOS_BITS - 1)));
   assign irq_event[`IRQ_RESTORE] = ce & os_tick & carrier_loss & mark_now;

   // raw recovery gives a shortened high phase; the receive attenuator evens it out
   always_comb begin
      if (ja_rx_active) begin
         rec_clk = (os_phase < `OS_MID); // [R11]
      end else begin
         rec_clk = (os_phase != 4'h0) && (os_phase < `OS_SHORT_HIGH_END); // [R11]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         recovered_clock_out <= 1'b0;
      end else if (ce) begin
         recovered_clock_out <= carrier_loss ? mclk_v : rec_clk; // [R10]
      end
   end

   // ---------------------------------------------------------------
   // transmit pulse timing
   // ---------------------------------------------------------------
   // only the rising edge of the transmit clock starts a pulse, so its duty cycle has no say
   logic txclk_d;
   logic [PULSE_W-1:0] pulse_left;
   logic pulse_pos;
   logic pulse_neg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txclk_d <= 1'b0;
         pulse_left <= '0;
         pulse_pos <= 1'b0;
         pulse_neg <= 1'b0;
      end else if (ce) begin
         txclk_d <= txclk_v;
         if (line_cfg.tx_power_down) begin
            pulse_left <= '0; // [R7]
         end else if (txclk_v && !txclk_d) begin
            pulse_left <= PULSE_W'(PULSE_CYC); // [R12]
            // both marks at once is illegal on an ami line; send a space
            pulse_pos <= tx_mark_pos & ~tx_mark_neg;
            pulse_neg <= tx_mark_neg & ~tx_mark_pos;
         end else if (pulse_left != '0) begin
            pulse_left <= pulse_left - PULSE_W'(1); // [R12]
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_line_pos <= 1'b0;
         tx_line_neg <= 1'b0;
         tx_line_oe <= 1'b0;
      end else if (ce) begin
         tx_line_oe <= ~line_cfg.tx_power_down; // [R7]
         tx_line_pos <= ~line_cfg.tx_power_down & (pulse_left != '0) & pulse_pos; // [R12]
         tx_line_neg <= ~line_cfg.tx_power_down & (pulse_left != '0) & pulse_neg; // [R12]
      end
   end

endmodule

// *** testbench/t1_line_assertions.sv ***
// Purpose: concurrent checks on the line interface control block ports
// Assumes: ce held high by the bench
// Notes: bound to every instance of the design module
`timescale 1ns/1ps
`include "t1_line_params.svh"
module t1_line_checker
   import t1_line_pkg::*;
#(
   parameter int LOS_BITS = 192
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic mclk,
   input wire logic tx_line_pos,
   input wire logic tx_line_neg,
   input wire logic tx_line_oe,
   input wire logic recovered_clock_out,
   input wire logic carrier_loss,
   input wire line_cfg_t line_cfg
);
   // ---------
   // checks
   // ---------
   logic [7:0] shadow;
   logic hit, wr_done, rd_done, tx_any;
   assign hit = psel && penable && pready && paddr == {24'h0, `LIC_ADDR};
   assign wr_done = hit && pwrite && pstrb[0];
   assign rd_done = hit && !pwrite;
   assign tx_any = tx_line_pos | tx_line_neg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shadow <= `LIC_RESET;
      end else if (wr_done) begin
         shadow <= pwdata[7:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   waveform_map_a: assert property (wr_done |=> line_cfg.waveform == $past(pwdata[7:5]))
      else $error("build-out select not taken from bits 7 to 5");
   csu_code_a: assert property (line_cfg.csu_mode == (line_cfg.waveform >= `CSU_FIRST_CODE))
      else $error("csu mode does not follow build-out code");
   eq_limit_a: assert property (wr_done |=> line_cfg.eq_limit_db ==
      ($past(pwdata[4]) ? `EQ_LIMIT_WIDE_DB : `EQ_LIMIT_NARROW_DB)) else $error("equalizer limit wrong");
   ja_config_a: assert property (wr_done |=> {line_cfg.ja_tx_side, line_cfg.ja_bypass} ==
      $past({pwdata[3], pwdata[1]}) && line_cfg.ja_depth_bits == ($past(pwdata[2]) ?
      `JA_DEPTH_SHALLOW : `JA_DEPTH_DEEP)) else $error("attenuator settings wrong");
   tx_off_a: assert property (line_cfg.tx_power_down [*2] |-> !tx_line_oe && !tx_any)
      else $error("transmitter drives while powered down");
   tx_on_a: assert property (!line_cfg.tx_power_down [*3] |-> tx_line_oe)
      else $error("transmitter not driving");
   loss_clock_a: assert property (carrier_loss [*8] ##0 $rose(recovered_clock_out) |->
      $past(mclk, 2) || $past(mclk, 4) || $past(mclk, 6)) else $error("clock not from master on loss");
   pulse_width_a: assert property (disable iff (!presetn || line_cfg.tx_power_down)
      $rose(tx_any) |-> tx_any [*8] ##1 tx_any [*8] ##1 !tx_any) else $error("pulse not 16 cycles");
   read_back_a: assert property (rd_done |-> prdata == {24'h0, shadow})
      else $error("control register read back wrong");
   cover property (wr_done);
   cover property ($rose(carrier_loss));
   cover property ($rose(tx_any));
   cover property (psel && penable && pready && pslverr);
endmodule
bind t1_line_interface_control t1_line_checker #(.LOS_BITS(LOS_BITS)) chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .mclk(mclk), .tx_line_pos(tx_line_pos),
   .tx_line_neg(tx_line_neg), .tx_line_oe(tx_line_oe), .recovered_clock_out(recovered_clock_out),
   .carrier_loss(carrier_loss), .line_cfg(line_cfg));

// *** testbench/t1_line_partner.sv ***
// Purpose: line-side model: master clock, transmit clock, receive pair
// Assumes: bit period equals master clock period
// Notes: never two spaces in a row while sending
`timescale 1ns/1ps
module t1_line_partner (
   input wire logic send,
   input wire logic [9:0] tx_high_ns,
   output logic mclk,
   output logic tx_clock_in,
   output logic rx_line_pos,
   output logic rx_line_neg
);
   // ---------
   // line model
   // ---------
   logic pol, mark, last;
   // master clock at the T1 rate
   initial begin
      mclk = 1'b0;
      forever #323.834 mclk = ~mclk;
   end
   // high time is varied so pulse width can be shown duty independent
   initial begin
      tx_clock_in = 1'b0;
      forever begin
         #(647.668 - tx_high_ns) tx_clock_in = 1'b1;
         #(tx_high_ns) tx_clock_in = 1'b0;
      end
   end
   // return-to-zero marks, alternating rail; silence is no pulse on either rail
   initial begin
      {rx_line_pos, rx_line_neg, pol, last} = 4'h0;
      forever begin
         mark = send && (last || $urandom_range(1) == 1);
         last = !mark;
         pol = pol ^ mark;
         rx_line_pos = mark && pol;
         rx_line_neg = mark && !pol;
         #323.834 {rx_line_pos, rx_line_neg} = 2'h0;
         #323.834;
      end
   end
endmodule

// *** testbench/test_t1_line_interface_control.sv ***
// Purpose: self-checking bench for the line interface control block
// Assumes: LOS_BITS cut to 4 to keep loss detection short
// Notes: expected line_cfg values come from exp_cfg
`timescale 1ns/1ps
`include "t1_line_params.svh"
module test_t1_line_interface_control;
   import t1_line_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   // set before time zero so the line model never starts from unknown levels
   logic send = 1'b1;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [7:0] v;
   logic [9:0] tx_high_ns = 10'd100;
   logic mclk, tx_clock_in, rx_line_pos, rx_line_neg, tx_mark_pos, tx_mark_neg, tx_line_pos, tx_line_neg;
   logic tx_line_oe, recovered_clock_out, rx_data, rx_data_valid, carrier_loss;
   line_cfg_t line_cfg;
   int miscompares, cmp_count, cycles, n, h, nv, nd;
   t1_line_interface_control #(.LOS_BITS(4)) DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .mclk(mclk), .tx_clock_in(tx_clock_in),
      .rx_line_pos(rx_line_pos), .rx_line_neg(rx_line_neg), .tx_mark_pos(tx_mark_pos),
      .tx_mark_neg(tx_mark_neg), .tx_line_pos(tx_line_pos), .tx_line_neg(tx_line_neg),
      .tx_line_oe(tx_line_oe), .recovered_clock_out(recovered_clock_out), .rx_data(rx_data),
      .rx_data_valid(rx_data_valid), .carrier_loss(carrier_loss), .line_cfg(line_cfg));
   t1_line_partner line (.send(send), .tx_high_ns(tx_high_ns), .mclk(mclk), .tx_clock_in(tx_clock_in),
      .rx_line_pos(rx_line_pos), .rx_line_neg(rx_line_neg));
   // ---------
   // helpers
   // ---------
   function automatic line_cfg_t exp_cfg(input logic [7:0] c);
      exp_cfg.waveform = lbo_t'(c[7:5]);
      exp_cfg.csu_mode = c[7:5] >= 3'h5;
      exp_cfg.eq_limit_db = c[4] ? 6'h1E : 6'h24;
      exp_cfg.ja_tx_side = c[3];
      exp_cfg.ja_depth_bits = c[2] ? 8'h20 : 8'h80;
      exp_cfg.ja_bypass = c[1];
      exp_cfg.tx_power_down = c[0];
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // idle edge at the end keeps psel from being assigned twice in one step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {24'h0, a};
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic pulse_len();
      n = 0;
      while (!(tx_line_pos | tx_line_neg) && n < 640) begin
         @(posedge pclk);
         n++;
      end
      n = 0;
      while (tx_line_pos | tx_line_neg) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic watch(input int cyc);
      int run;
      {n, h, nv, nd, run} = '0;
      repeat (cyc) begin
         @(posedge pclk);
         nv += int'(rx_data_valid === 1'b1);
         nd += int'(rx_data_valid === 1'b1 && rx_data === 1'b1);
         run = (recovered_clock_out === 1'b1) ? run + 1 : 0;
         n += int'(run == 1);
         h = (run > h) ? run : h;
      end
   endtask
   task automatic wait_for(input logic lvl);
      for (int k = 0; k < 2000 && carrier_loss !== lvl; k++) @(posedge pclk);
   endtask
   // ---------
   // stimulus
   // ---------
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      tx_mark_pos <= 1'($urandom);
      tx_mark_neg <= ~tx_mark_pos;
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         miscompares++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(3880));
      {psel, penable, pwrite, paddr, pwdata, pstrb, tx_mark_pos, tx_mark_neg, cycles} = '0;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `LIC_ADDR, 32'h0, 4'h0);
      check(rd, 32'h0);
      check(32'(line_cfg), 32'(exp_cfg(8'h00)));
      check(tx_line_oe, 1'b1);
      for (int i = 0; i < 8; i++) begin
         v = {i[2:0], 5'($urandom)};
         apb(1'b1, `LIC_ADDR, {24'($urandom), v}, 4'h1);
         apb(1'b0, `LIC_ADDR, 32'h0, 4'h0);
         check(rd, {24'h0, v});
         check(32'(line_cfg), 32'(exp_cfg(v)));
      end
      apb(1'b1, `LIC_ADDR, 32'h0, 4'h0);
      apb(1'b0, `LIC_ADDR, 32'h0, 4'h0);
      check(rd, {24'h0, v});
      apb(1'b0, 8'h90, 32'h0, 4'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      apb(1'b1, `LIC_ADDR, 32'h0, 4'h1);
      for (int i = 0; i < 2; i++) begin
         tx_high_ns = i ? 10'd540 : 10'd60;
         pulse_len();
         pulse_len();
         check(n, 32'(`PULSE_NS / `PCLK_NS));
      end
      watch(400);
      check(h >= 15, 1'b1);
      check(nv >= 11 && nv <= 13, 1'b1);
      check(nd >= 5 && nd <= nv, 1'b1);
      apb(1'b1, `LIC_ADDR, 32'h8, 4'h1);
      watch(400);
      check(h <= 14, 1'b1);
      apb(1'b1, `LIC_ADDR, 32'h1, 4'h1);
      pulse_len();
      check(n, 32'h0);
      check(tx_line_oe, 1'b0);
      apb(1'b0, `LINE_STATUS_ADDR, 32'h0, 4'h0);
      check(rd, 32'h2);
      apb(1'b1, `IRQ_MASK_ADDR, 32'h1, 4'h1);
      apb(1'b1, `IRQ_STATUS_ADDR, 32'h3, 4'h1);
      send = 1'b0;
      wait_for(1'b1);
      apb(1'b0, `IRQ_STATUS_ADDR, 32'h0, 4'h0);
      check(carrier_loss, 1'b1);
      check(irq, 1'b1);
      check(rd, 32'h1);
      apb(1'b0, `LINE_STATUS_ADDR, 32'h0, 4'h0);
      check(rd, 32'h3);
      watch(400);
      check(n >= 12 && n <= 13, 1'b1);
      check(nd, 32'h0);
      apb(1'b1, `IRQ_MASK_ADDR, 32'h0, 4'h1);
      check(irq, 1'b0);
      apb(1'b1, `IRQ_MASK_ADDR, 32'h1, 4'h1);
      check(irq, 1'b1);
      apb(1'b1, `IRQ_STATUS_ADDR, 32'h1, 4'h1);
      check(irq, 1'b0);
      send = 1'b1;
      wait_for(1'b0);
      apb(1'b0, `IRQ_STATUS_ADDR, 32'h0, 4'h0);
      check(carrier_loss, 1'b0);
      check(rd, 32'h2);
      wrap_up();
   end
endmodule
